// *** core/interrupt_priority_defs.vh ***
// Constants for the interrupt priority configuration block
`ifndef INTERRUPT_PRIORITY_DEFS_VH
`define INTERRUPT_PRIORITY_DEFS_VH

`define ADDR_W            5
`define DATA_W            16
`define NUM_SRC           21
`define SRC_IDX_W         5

// Register word offsets
`define OFS_PRIO_FLASH    5'h01
`define OFS_PRIO_SSG      5'h02
`define OFS_PRIO_I2C_SER  5'h03
`define OFS_PRIO_TMR_I2C  5'h04
`define OFS_STATUS        5'h18

// Writable bit masks; zero bits are reserved
`define MASK_PRIO_FLASH   16'h003F
`define MASK_PRIO_SSG     16'hC3FF
`define MASK_PRIO_I2C_SER 16'hC03F
`define MASK_PRIO_TMR_I2C 16'hFFFF

`define RST_PRIO          16'h0000

// Field encodings
`define FIELD_OFF         2'h0

// Status bit positions
`define ST_SNAP_BIT       0
`define ST_PEND_BIT       1
`define ST_LVL_LO         2
`define ST_SRC_LO         4
`define ST_WAKE_BIT       9
`define ST_RSVD_BIT       15

`endif

// *** core/prio_field_decode.v ***
// Registered decode of one 2-bit priority field for one request source
`timescale 1ns/10ps
`include "interrupt_priority_defs.vh"

module prio_field_decode
(
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Field and request
    input  wire [1:0] field,
    input  wire       request,
    // Decoded outputs
    output reg        enable_reg,
    output reg  [1:0] level_reg,
    output reg        active_reg
);

wire       enable_next;
wire [1:0] level_next;

assign enable_next = (field != `FIELD_OFF);
// Level is one below the code, so code 11 caps the source at level 2
assign level_next  = enable_next ? (field - 2'h1) : 2'h0;

always @(posedge clk or posedge reset)
begin
    if (reset)
    begin
        enable_reg <= 1'b0;
        level_reg  <= 2'h0;
        active_reg <= 1'b0;
    end
    else
    begin
        enable_reg <= enable_next;
        level_reg  <= level_next;
        active_reg <= enable_next & request;
    end
end

endmodule // prio_field_decode

// *** core/interrupt_priority_config.v ***
// Priority configuration registers, per-source decode, wake and pending select
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "interrupt_priority_defs.vh"

module interrupt_priority_config
(
    // Clock and reset
    input  wire                     SYS_CLK,
    input  wire                     RESET,
    // Register port
    input  wire [`ADDR_W-1:0]       ADDR,
    input  wire [`DATA_W-1:0]       WR_DATA,
    input  wire                     WR_STROBE,
    input  wire                     RD_STROBE,
    output reg  [`DATA_W-1:0]       RD_DATA,
    // Peripheral requests and low-power state
    input  wire [`NUM_SRC-1:0]      REQUEST,
    input  wire                     LOW_POWER,
    // Per-source decoded priority
    output wire [`NUM_SRC-1:0]      PRIO_ENABLE,
    output wire [2*`NUM_SRC-1:0]    PRIO_LEVEL,
    output wire [`NUM_SRC-1:0]      REQ_ACTIVE,
    // Arbitration result and wake
    output reg                      PEND_VALID,
    output reg  [1:0]               PEND_LEVEL,
    output reg  [`SRC_IDX_W-1:0]    PEND_SOURCE,
    output reg                      WAKE_REQUEST
);

////////////////////////////////////////////////////////////////////////////////
// Priority registers

reg  [`DATA_W-1:0] priority_flash_reg;
reg  [`DATA_W-1:0] priority_serial_spi_gpio_reg;
reg  [`DATA_W-1:0] priority_i2c_err_serial_rx_reg;
reg  [`DATA_W-1:0] priority_timer_i2c_reg;

wire sel_flash;
wire sel_ssg;
wire sel_i2c_ser;
wire sel_tmr_i2c;
wire sel_status;

assign sel_flash   = (ADDR == `OFS_PRIO_FLASH);
assign sel_ssg     = (ADDR == `OFS_PRIO_SSG);
assign sel_i2c_ser = (ADDR == `OFS_PRIO_I2C_SER);
assign sel_tmr_i2c = (ADDR == `OFS_PRIO_TMR_I2C);
assign sel_status  = (ADDR == `OFS_STATUS);

// Reserved positions are masked at write so they can never hold a one
always @(posedge SYS_CLK or posedge RESET)
begin
    if (RESET)
    begin
        priority_flash_reg             <= `RST_PRIO;
        priority_serial_spi_gpio_reg   <= `RST_PRIO;
        priority_i2c_err_serial_rx_reg <= `RST_PRIO;
        priority_timer_i2c_reg         <= `RST_PRIO;
    end
    else if (WR_STROBE)
    begin
        if (sel_flash)
        begin
            priority_flash_reg <= WR_DATA & `MASK_PRIO_FLASH;
        end
        if (sel_ssg)
        begin
            priority_serial_spi_gpio_reg <= WR_DATA & `MASK_PRIO_SSG;
        end
        if (sel_i2c_ser)
        begin
            priority_i2c_err_serial_rx_reg <=
                WR_DATA & `MASK_PRIO_I2C_SER;
        end
        if (sel_tmr_i2c)
        begin
            priority_timer_i2c_reg <= WR_DATA & `MASK_PRIO_TMR_I2C;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Field extraction

wire [1:0] flash_buffers_empty_prio;
wire [1:0] flash_cmd_done_prio;
wire [1:0] flash_fault_prio;
wire [1:0] serial0_tx_empty_prio;
wire [1:0] spi0_tx_empty_prio;
wire [1:0] spi0_rx_full_prio;
wire [1:0] port_a_pin_prio;
wire [1:0] port_b_pin_prio;
wire [1:0] port_c_pin_prio;
wire [1:0] twowire_fault_prio;
wire [1:0] serial0_rx_full_prio;
wire [1:0] serial0_rx_fault_prio;
wire [1:0] serial0_tx_idle_prio;
wire [1:0] timer_ch3_prio;
wire [1:0] timer_ch2_prio;
wire [1:0] timer_ch1_prio;
wire [1:0] timer_ch0_prio;
wire [1:0] twowire_state_prio;
wire [1:0] twowire_send_prio;
wire [1:0] twowire_recv_prio;
wire [1:0] twowire_general_prio;

assign flash_buffers_empty_prio = priority_flash_reg[5:4];
assign flash_cmd_done_prio      = priority_flash_reg[3:2];
assign flash_fault_prio         = priority_flash_reg[1:0];

assign serial0_tx_empty_prio = priority_serial_spi_gpio_reg[15:14];
assign spi0_tx_empty_prio    = priority_serial_spi_gpio_reg[9:8];
assign spi0_rx_full_prio     = priority_serial_spi_gpio_reg[7:6];
assign port_a_pin_prio       = priority_serial_spi_gpio_reg[5:4];
assign port_b_pin_prio       = priority_serial_spi_gpio_reg[3:2];
assign port_c_pin_prio       = priority_serial_spi_gpio_reg[1:0];

assign twowire_fault_prio    = priority_i2c_err_serial_rx_reg[15:14];
assign serial0_rx_full_prio  = priority_i2c_err_serial_rx_reg[5:4];
assign serial0_rx_fault_prio = priority_i2c_err_serial_rx_reg[3:2];
assign serial0_tx_idle_prio  = priority_i2c_err_serial_rx_reg[1:0];

assign timer_ch3_prio       = priority_timer_i2c_reg[15:14];
assign timer_ch2_prio       = priority_timer_i2c_reg[13:12];
assign timer_ch1_prio       = priority_timer_i2c_reg[11:10];
assign timer_ch0_prio       = priority_timer_i2c_reg[9:8];
assign twowire_state_prio   = priority_timer_i2c_reg[7:6];
assign twowire_send_prio    = priority_timer_i2c_reg[5:4];
assign twowire_recv_prio    = priority_timer_i2c_reg[3:2];
assign twowire_general_prio = priority_timer_i2c_reg[1:0];

// Source index order, lowest index wins a tie at equal level
wire [2*`NUM_SRC-1:0] all_fields;

assign all_fields = {
    timer_ch3_prio,        // 20
    timer_ch2_prio,        // 19
    timer_ch1_prio,        // 18
    timer_ch0_prio,        // 17
    twowire_state_prio,    // 16
    twowire_send_prio,     // 15
    twowire_recv_prio,     // 14
    twowire_general_prio,  // 13
    twowire_fault_prio,    // 12
    serial0_rx_full_prio,  // 11
    serial0_rx_fault_prio, // 10
    serial0_tx_idle_prio,  // 9
    serial0_tx_empty_prio, // 8
    spi0_tx_empty_prio,    // 7
    spi0_rx_full_prio,     // 6
    port_a_pin_prio,       // 5
    port_b_pin_prio,       // 4
    port_c_pin_prio,       // 3
    flash_buffers_empty_prio, // 2
    flash_cmd_done_prio,   // 1
    flash_fault_prio       // 0
};

////////////////////////////////////////////////////////////////////////////////
// Per-source decode

genvar g;
generate
    for (g = 0; g < `NUM_SRC; g = g + 1)
    begin : src
        prio_field_decode u_dec
        (
            .clk        (SYS_CLK),
            .reset      (RESET),
            .field      (all_fields[2*g+1:2*g]),
            .request    (REQUEST[g]),
            .enable_reg (PRIO_ENABLE[g]),
            .level_reg  (PRIO_LEVEL[2*g+1:2*g]),
            .active_reg (REQ_ACTIVE[g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Highest pending level, presented to the core side

reg                  best_valid;
reg [1:0]            best_level;
reg [`SRC_IDX_W-1:0] best_src;
integer              i;

always @*
begin
    best_valid = 1'b0;
    best_level = 2'h0;
    best_src   = {`SRC_IDX_W{1'b0}};
    for (i = 0; i < `NUM_SRC; i = i + 1)
    begin
        // Strict compare keeps the lower index on a tie
        if (REQ_ACTIVE[i] &&
            (!best_valid || (PRIO_LEVEL[2*i+:2] > best_level)))
        begin
            best_valid = 1'b1;
            best_level = PRIO_LEVEL[2*i+:2];
            best_src   = i[`SRC_IDX_W-1:0];
        end
    end
end

always @(posedge SYS_CLK or posedge RESET)
begin
    if (RESET)
    begin
        PEND_VALID  <= 1'b0;
        PEND_LEVEL  <= 2'h0;
        PEND_SOURCE <= {`SRC_IDX_W{1'b0}};
    end
    else
    begin
        PEND_VALID  <= best_valid;
        PEND_LEVEL  <= best_level;
        PEND_SOURCE <= best_src;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Wake from wait or stop

reg                 low_power_prev_reg;
reg [`NUM_SRC-1:0]  wake_mask_reg;
reg                 snap_held_reg;
reg [`NUM_SRC-1:0]  field_nonzero;
integer             k;

always @*
begin
    field_nonzero = {`NUM_SRC{1'b0}};
    for (k = 0; k < `NUM_SRC; k = k + 1)
    begin
        field_nonzero[k] = (all_fields[2*k+:2] != `FIELD_OFF);
    end
end

// Mask is frozen on entry; later field writes cannot arm a wake source
always @(posedge SYS_CLK or posedge RESET)
begin
    if (RESET)
    begin
        low_power_prev_reg <= 1'b0;
        wake_mask_reg      <= {`NUM_SRC{1'b0}};
        snap_held_reg      <= 1'b0;
        WAKE_REQUEST       <= 1'b0;
    end
    else
    begin
        low_power_prev_reg <= LOW_POWER;
        if (LOW_POWER && !low_power_prev_reg)
        begin
            wake_mask_reg <= field_nonzero;
            snap_held_reg <= 1'b1;
        end
        else if (!LOW_POWER)
        begin
            snap_held_reg <= 1'b0;
        end
        WAKE_REQUEST <= LOW_POWER && low_power_prev_reg &&
                        |(REQUEST & wake_mask_reg);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Reserved-write flag and status

wire rsvd_write;
reg  rsvd_seen_reg;
wire rsvd_clear;

// Flags software that broke the zero-write convention for reserved bits
assign rsvd_write = WR_STROBE &&
    ((sel_flash   && |(WR_DATA & ~`MASK_PRIO_FLASH))   ||
     (sel_ssg     && |(WR_DATA & ~`MASK_PRIO_SSG))     ||
     (sel_i2c_ser && |(WR_DATA & ~`MASK_PRIO_I2C_SER)));
assign rsvd_clear = WR_STROBE && sel_status && WR_DATA[`ST_RSVD_BIT];

// A new violation in the clearing cycle wins over the clear
always @(posedge SYS_CLK or posedge RESET)
begin
    if (RESET)
    begin
        rsvd_seen_reg <= 1'b0;
    end
    else if (rsvd_write)
    begin
        rsvd_seen_reg <= 1'b1;
    end
    else if (rsvd_clear)
    begin
        rsvd_seen_reg <= 1'b0;
    end
end

wire [`DATA_W-1:0] status_word;

assign status_word = {
    rsvd_seen_reg,
    5'h00,
    WAKE_REQUEST,
    PEND_SOURCE,
    PEND_LEVEL,
    PEND_VALID,
    snap_held_reg
};

////////////////////////////////////////////////////////////////////////////////
// Read port

reg [`DATA_W-1:0] rd_data_next;

always @*
begin
    rd_data_next = {`DATA_W{1'b0}};
    case (ADDR)
        `OFS_PRIO_FLASH:    rd_data_next = priority_flash_reg;
        `OFS_PRIO_SSG:      rd_data_next = priority_serial_spi_gpio_reg;
        `OFS_PRIO_I2C_SER:  rd_data_next = priority_i2c_err_serial_rx_reg;
        `OFS_PRIO_TMR_I2C:  rd_data_next = priority_timer_i2c_reg;
        `OFS_STATUS:        rd_data_next = status_word;
        default:            rd_data_next = {`DATA_W{1'b0}};
    endcase
end

// Data stand only in the cycle after the strobe and read zero otherwise
always @(posedge SYS_CLK or posedge RESET)
begin
    if (RESET)
    begin
        RD_DATA <= {`DATA_W{1'b0}};
    end
    else if (RD_STROBE)
    begin
        RD_DATA <= rd_data_next;
    end
    else
    begin
        RD_DATA <= {`DATA_W{1'b0}};
    end
end

endmodule // interrupt_priority_config

// *** test/prio_cfg_monitor.sv ***
// Port-level assertions for the interrupt priority configuration block
`timescale 1ns/10ps
`include "interrupt_priority_defs.vh"
module prio_cfg_monitor
(
    // Clock and reset
    input wire                   SYS_CLK,
    input wire                   RESET,
    // Register port
    input wire [`ADDR_W-1:0]     ADDR,
    input wire [`DATA_W-1:0]     WR_DATA,
    input wire                   WR_STROBE,
    input wire                   RD_STROBE,
    input wire [`DATA_W-1:0]     RD_DATA,
    // Requests and low power
    input wire [`NUM_SRC-1:0]    REQUEST,
    input wire                   LOW_POWER,
    // Decoded priority and arbitration
    input wire [`NUM_SRC-1:0]    PRIO_ENABLE,
    input wire [2*`NUM_SRC-1:0]  PRIO_LEVEL,
    input wire [`NUM_SRC-1:0]    REQ_ACTIVE,
    input wire                   PEND_VALID,
    input wire [1:0]             PEND_LEVEL,
    input wire [`SRC_IDX_W-1:0]  PEND_SOURCE,
    input wire                   WAKE_REQUEST
);
reg [`NUM_SRC-1:0] act_q;
always @(posedge SYS_CLK or posedge RESET)
    if (RESET)
        act_q <= {`NUM_SRC{1'b0}};
    else
        act_q <= REQ_ACTIVE;
default clocking cb @(posedge SYS_CLK); endclocking
default disable iff (RESET);
////////////////////////////////////////////////////////////////////////////
property p_lvl_max;
    PEND_VALID |-> PEND_LEVEL != 2'h3;
endproperty
a_lvl_max: assert property (p_lvl_max) else $error("level above 2");
property p_act_req;
    (REQ_ACTIVE & ~$past(REQUEST)) == {`NUM_SRC{1'b0}};
endproperty
a_act_req: assert property (p_act_req) else $error("active w/o req");
property p_pend;
    PEND_VALID == (act_q != {`NUM_SRC{1'b0}});
endproperty
a_pend: assert property (p_pend) else $error("pending mismatch");
property p_winner;
    PEND_VALID |-> act_q[PEND_SOURCE];
endproperty
a_winner: assert property (p_winner) else $error("idle winner");
property p_rst;
    $fell(RESET) |-> PRIO_ENABLE == {`NUM_SRC{1'b0}} && !PEND_VALID;
endproperty
a_rst: assert property (p_rst) else $error("not clear at reset");
property p_wake;
    WAKE_REQUEST |-> $past(LOW_POWER) && $past(LOW_POWER, 2)
        && $past(REQUEST) != {`NUM_SRC{1'b0}};
endproperty
a_wake: assert property (p_wake) else $error("wake w/o cause");
property p_rsv_ssg;
    $past(RD_STROBE) && $past(ADDR) == `OFS_PRIO_SSG
        |-> (RD_DATA & ~`MASK_PRIO_SSG) == 16'h0000;
endproperty
a_rsv_ssg: assert property (p_rsv_ssg) else $error("rsvd bits set");
sequence s_fault3;
    WR_STROBE && ADDR == `OFS_PRIO_FLASH && WR_DATA[1:0] == 2'h3
        ##1 !(WR_STROBE && ADDR == `OFS_PRIO_FLASH);
endsequence
property p_fault3;
    s_fault3 |=> PRIO_ENABLE[0] && PRIO_LEVEL[1:0] == 2'h2;
endproperty
a_fault3: assert property (p_fault3) else $error("bad fault level");
c_wake: cover property (WAKE_REQUEST);
c_top: cover property (PEND_VALID && PEND_LEVEL == 2'h2);
c_read: cover property ($past(RD_STROBE) && RD_DATA != 16'h0000);
endmodule // prio_cfg_monitor

bind interrupt_priority_config prio_cfg_monitor u_prio_cfg_monitor
(
    .SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA),
    .REQUEST(REQUEST), .LOW_POWER(LOW_POWER), .PRIO_ENABLE(PRIO_ENABLE),
    .PRIO_LEVEL(PRIO_LEVEL), .REQ_ACTIVE(REQ_ACTIVE),
    .PEND_VALID(PEND_VALID), .PEND_LEVEL(PEND_LEVEL),
    .PEND_SOURCE(PEND_SOURCE), .WAKE_REQUEST(WAKE_REQUEST)
);

// *** test/periph_core_model.sv ***
// Peripherals and core: registered request lines and low-power flag
`timescale 1ns/10ps
`include "interrupt_priority_defs.vh"
module periph_core_model
(
    // Clock and reset
    input  wire                 clk,
    input  wire                 reset,
    // Commands from the bench
    input  wire [`NUM_SRC-1:0]  raise,
    input  wire                 sleep,
    // Lines into the block
    output reg  [`NUM_SRC-1:0]  req_out,
    output reg                  low_power
);
// Lines leave a flop, so they move only just after an edge
always @(posedge clk or posedge reset)
    if (reset)
    begin
        req_out <= {`NUM_SRC{1'b0}};
        low_power <= 1'b0;
    end
    else
    begin
        req_out <= raise;
        low_power <= sleep;
    end
endmodule // periph_core_model

// *** test/tb_interrupt_priority_config.sv ***
// Self-checking bench for the interrupt priority configuration block
`timescale 1ns/10ps
`include "interrupt_priority_defs.vh"
`define CHK(a, b) begin check_count = check_count + 1; \
    if ((a) !== (b)) begin n_errors = n_errors + 1; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_interrupt_priority_config;
reg                    clk, rst, wr, rd, sleep;
reg  [`ADDR_W-1:0]     addr;
reg  [`DATA_W-1:0]     wdata;
reg  [`NUM_SRC-1:0]    raise;
wire [`DATA_W-1:0]     rdata;
wire [`NUM_SRC-1:0]    request, en, act;
wire [2*`NUM_SRC-1:0]  lvl;
wire                   low_power, pv, wake;
wire [1:0]             pl;
wire [`SRC_IDX_W-1:0]  ps;
integer                n_errors, check_count, cyc;
interrupt_priority_config u_interrupt_priority_config
(
    .SYS_CLK(clk), .RESET(rst), .ADDR(addr), .WR_DATA(wdata),
    .WR_STROBE(wr), .RD_STROBE(rd), .RD_DATA(rdata), .REQUEST(request),
    .LOW_POWER(low_power), .PRIO_ENABLE(en), .PRIO_LEVEL(lvl),
    .REQ_ACTIVE(act), .PEND_VALID(pv), .PEND_LEVEL(pl),
    .PEND_SOURCE(ps), .WAKE_REQUEST(wake)
);
periph_core_model u_periph_core_model
(
    .clk(clk), .reset(rst), .raise(raise), .sleep(sleep),
    .req_out(request), .low_power(low_power)
);
////////////////////////////////////////////////////////////////////////////
task wrap_up;
begin
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
end
endtask
task wr_reg(input [`ADDR_W-1:0] a, input [`DATA_W-1:0] d);
begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
end
endtask
// Read data stand only in the cycle after the strobe
task rd_chk(input [`ADDR_W-1:0] a, input [`DATA_W-1:0] e);
begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
end
endtask
task wait_n(input integer n);
begin
    repeat (n) @(posedge clk);
    #1;
end
endtask
////////////////////////////////////////////////////////////////////////////
task t_fields;
    integer k, i;
    reg [15:0] v, s2, s3, t;
    reg [41:0] fv, el;
    reg [20:0] ee;
begin
    for (k = 0; k < 4; k = k + 1)
    begin
        v = k == 0 ? 16'hFFFF : k == 1 ? 16'h1B1B :
            k == 2 ? 16'hE4E4 : 16'h5A96;
        s2 = ~v;
        s3 = {v[7:0], v[15:8]};
        t = v ^ 16'h3C3C;
        wr_reg(`OFS_PRIO_FLASH, v);
        wr_reg(`OFS_PRIO_SSG, s2);
        wr_reg(`OFS_PRIO_I2C_SER, s3);
        wr_reg(`OFS_PRIO_TMR_I2C, t);
        wait_n(3);
        fv = {t, s3[15:14], s3[5:0], s2[15:14], s2[9:0], v[5:0]};
        for (i = 0; i < `NUM_SRC; i = i + 1)
        begin
            ee[i] = |fv[2*i +: 2];
            el[2*i +: 2] = ee[i] ? fv[2*i +: 2] - 2'h1 : 2'h0;
        end
        `CHK(en, ee)
        `CHK(lvl, el)
        rd_chk(`OFS_PRIO_FLASH, v & `MASK_PRIO_FLASH);
        rd_chk(`OFS_PRIO_SSG, s2 & `MASK_PRIO_SSG);
        rd_chk(`OFS_PRIO_I2C_SER, s3 & `MASK_PRIO_I2C_SER);
        rd_chk(`OFS_PRIO_TMR_I2C, t);
    end
end
endtask
task t_reset;
    integer a;
begin
    @(posedge clk);
    rst <= 1'b1;
    wait_n(2);
    `CHK(en, 21'h000000)
    @(posedge clk);
    rst <= 1'b0;
    for (a = 1; a < 5; a = a + 1)
        rd_chk(a[`ADDR_W-1:0], 16'h0000);
end
endtask
task t_unmap;
begin
    wr_reg(5'h05, 16'hFFFF);
    rd_chk(5'h05, 16'h0000);
    rd_chk(5'h00, 16'h0000);
    rd_chk(`OFS_PRIO_FLASH, 16'h0000);
    // Ones only in reserved bits: field stays clear, flag latches
    wr_reg(`OFS_PRIO_SSG, 16'h3C00);
    rd_chk(`OFS_STATUS, 16'h8000);
    wr_reg(`OFS_STATUS, 16'h8000);
    rd_chk(`OFS_STATUS, 16'h0000);
    rd_chk(`OFS_PRIO_SSG, 16'h0000);
end
endtask
task arb(input [20:0] r, input v, input [1:0] l, input [4:0] s);
begin
    @(posedge clk);
    raise <= r;
    wait_n(4);
    `CHK(act, r & 21'h100821)
    `CHK(pv, v)
    if (v)
        `CHK({pl, ps}, {l, s})
end
endtask
task t_arb;
begin
    wr_reg(`OFS_PRIO_FLASH, 16'h0001);
    wr_reg(`OFS_PRIO_SSG, 16'h0020);
    wr_reg(`OFS_PRIO_I2C_SER, 16'h0010);
    wr_reg(`OFS_PRIO_TMR_I2C, 16'hC000);
    arb(21'h1FFFFF, 1'b1, 2'h2, 5'd20);
    arb(21'h000823, 1'b1, 2'h1, 5'd5);
    arb(21'h000801, 1'b1, 2'h0, 5'd0);
    arb(21'h000002, 1'b0, 2'h0, 5'd0);
    arb(21'h000000, 1'b0, 2'h0, 5'd0);
end
endtask
// The wake mask is frozen at entry, so later field writes must not count
task t_wake;
begin
    @(posedge clk);
    sleep <= 1'b1;
    wait_n(3);
    wr_reg(`OFS_PRIO_FLASH, 16'h0004);
    @(posedge clk);
    raise <= 21'h000002;
    wait_n(4);
    `CHK(wake, 1'b0)
    @(posedge clk);
    raise <= 21'h000001;
    wait_n(4);
    `CHK(wake, 1'b1)
    rd_chk(`OFS_STATUS, 16'h0201);
    @(posedge clk);
    sleep <= 1'b0;
    wait_n(4);
    `CHK(wake, 1'b0)
end
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
        n_errors = n_errors + 1;
        wrap_up;
    end
end
initial
begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    sleep = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    raise = 21'h000000;
    n_errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_fields;
    t_reset;
    t_unmap;
    t_arb;
    t_wake;
    wrap_up;
end
endmodule // tb_interrupt_priority_config
